/* irsl_link_fsm.sv */
// Functional notes
// [RULE1] Polling runs the link at 9600 baud.
// [RULE2] Primary sends numbered discoveries, then identification.
// [RULE3] Answer only discovery slot 2.
// [RULE4] Keep answering slot 2 every poll.
// [RULE5] Enter discovery after slot answer and identification.
// [RULE6] Setup handled locally; clear-to-send inhibits host.
// [RULE7] Answer primary parameters; use highest common rate.
// [RULE8] Never offer more than 115.2 kbaud.
// [RULE9] Answer service name, address, capability queries.
// [RULE10] Stop host serial while optical data arrives.
// [RULE11] Host obeys flow control or bytes lost.
// [RULE12] Check frames; keep exchanging empty frames.
// [RULE13] Confirm close command, then disconnect; here carrier drops first, confirmation comes with the return to disconnected.
// [RULE14] Ten idle seconds fall back to disconnected.
// [RULE15] Pass received payload to host uninterpreted.
// [RULE16] Frames use C0 start, CRC, C1 end.
// [RULE17] Carrier detect only while connected.
// [RULE18] High clear-to-send forbids host sending.
// [RULE19] Reset: disconnected, default rate, host inhibited.
`timescale 1ns/1ps
`default_nettype none
`include "irsl_params.svh"

// Small FIFO between the optical receiver and the host serial transmitter.
module irsl_fifo #(
	parameter int WIDTH = `IRSL_FIFO_WIDTH,
	parameter int DEPTH = `IRSL_FIFO_DEPTH
) (
	input wire logic clock, // System clock.
	input wire logic rst, // Synchronous reset.
	input wire logic ce, // Clock enable.
	input wire logic in_valid, // Write data offered.
	output logic in_ready, // Space available.
	input wire logic [WIDTH-1:0] in_data, // Write data.
	output logic out_valid, // Data available.
	input wire logic out_ready, // Reader takes data.
	output logic [WIDTH-1:0] out_data // Read data.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
	logic [AW-1:0] wr_ptr; // Write index.
	logic [AW-1:0] rd_ptr; // Read index.
	logic [AW:0] count; // Words held.
	logic do_wr; // Write happens.
	logic do_rd; // Read happens.

	// Handshakes are combinational from the fill count.
	assign in_ready = (count != (AW+1)'(DEPTH)); // Full once DEPTH words are held.
	assign out_valid = (count != '0);
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// Storage write.
	always_ff @(posedge clock) begin
		if (ce && do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and count.
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (ce) begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule : irsl_fifo

// Connection state machine of the secondary station.
module irsl_link_fsm
	import irsl_pkg::*;
#(
	parameter int IDLE_CYCLES = `IRSL_IDLE_CYCLES
) (
	input wire logic clock, // System clock, 20 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic ce, // Clock enable; low freezes all state.
	input wire logic rx_frame_valid, // One-cycle pulse: frame decoded.
	input wire irsl_frame_t rx_frame, // Decoded frame fields.
	input wire logic rx_active_pin, // Optical receive in progress, async.
	input wire logic rx_byte_valid, // Payload byte strobe from decoder.
	input wire logic [7:0] rx_byte, // Payload byte.
	input wire logic [16:0] primary_baud, // Rate offered by the primary.
	output logic reply_valid, // One-cycle pulse: send a response.
	output irsl_reply_t reply, // Response request.
	output logic [16:0] link_baud, // Current optical rate.
	output logic host_valid, // Byte for the host serial port.
	input wire logic host_ready, // Host transmitter takes byte.
	output logic [7:0] host_data, // Byte to the host.
	output logic rx_stall, // Decoder must stall payload.
	output logic cts, // High: host must not send.
	output logic carrier_detect, // High while linked.
	output logic [2:0] link_state // State for observation.
);
	irsl_state_t state; // Present connection state.
	irsl_state_t next_state; // State for the next edge.
	logic [2:0] rx_sync; // Three-stage pin synchroniser.
	logic rx_active; // Filtered receive activity.
	logic slot_answered; // Slot 2 has been answered this poll.
	logic [31:0] idle_count; // Cycles since the last frame.
	logic good_frame; // A frame with good check arrived.
	logic fifo_in_ready; // FIFO space.
	logic [7:0] fifo_out_data; // FIFO head.

	assign good_frame = rx_frame_valid && rx_frame.crc_ok; // [RULE12] [RULE16]
	assign link_state = state;

	// Synchroniser; a change counts once stages two and three agree.
	always_ff @(posedge clock) begin
		if (rst) begin
			rx_sync <= 3'h0;
			rx_active <= 1'b0;
		end else if (ce) begin
			rx_sync <= {rx_sync[1:0], rx_active_pin};
			if (rx_sync[1] == rx_sync[2]) begin
				rx_active <= rx_sync[2];
			end
		end
	end

	// Next-state decision from decoded frames and the idle timer.
	always_comb begin
		next_state = state;
		unique case (state)
			IRSL_NDM: begin
				// Identification only moves on if our slot was answered.
				if (good_frame && rx_frame.kind == `IRSL_KIND_BCAST_ID && slot_answered) begin
					next_state = IRSL_DISC_PARAMS; // [RULE5] [RULE2]
				end
			end
			IRSL_DISC_PARAMS: begin
				if (good_frame && rx_frame.kind == `IRSL_KIND_PARAMS) begin
					next_state = IRSL_DISC_IAS; // [RULE7]
				end
			end
			IRSL_DISC_IAS: begin
				// The first data frame marks the end of service queries.
				if (good_frame && rx_frame.kind == `IRSL_KIND_DATA) begin
					next_state = IRSL_NCM;
				end
			end
			IRSL_NCM: begin
				if (good_frame && rx_frame.kind == `IRSL_KIND_CLOSE) begin
					next_state = IRSL_CLOSING; // [RULE13]
				end
			end
			IRSL_CLOSING: begin
				// Confirmation is registered this cycle and appears together with the disconnect.
				next_state = IRSL_NDM; // [RULE13]
			end
		endcase
		// Silence after leaving disconnected drops the link.
		if (state != IRSL_NDM && idle_count >= 32'(IDLE_CYCLES - 1)) begin
			next_state = IRSL_NDM; // [RULE14]
		end
	end

	// State register.
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= IRSL_NDM; // [RULE19]
		end else if (ce) begin
			state <= next_state;
		end
	end

	// Slot bookkeeping: a new poll starts with discovery number zero.
	always_ff @(posedge clock) begin
		if (rst) begin
			slot_answered <= 1'b0;
		end else if (ce) begin
			if (state != IRSL_NDM) begin
				slot_answered <= 1'b0;
			end else if (good_frame && rx_frame.kind == `IRSL_KIND_XID) begin
				if (rx_frame.slot == `IRSL_OWN_SLOT) begin
					slot_answered <= 1'b1; // [RULE3] [RULE4]
				end else if (rx_frame.slot == 8'h00) begin
					slot_answered <= 1'b0; // [RULE2]
				end
			end
		end
	end

	// Inactivity timer, restarted by every received frame.
	always_ff @(posedge clock) begin
		if (rst) begin
			idle_count <= 32'h0;
		end else if (ce) begin
			if (rx_frame_valid || state == IRSL_NDM) begin
				idle_count <= 32'h0;
			end else if (idle_count < 32'(IDLE_CYCLES - 1)) begin
				idle_count <= idle_count + 32'h1; // [RULE14]
			end
		end
	end

	// Response requests; all setup answers are made without the host.
	always_ff @(posedge clock) begin
		if (rst) begin
			reply_valid <= 1'b0;
			reply <= '0;
		end else if (ce) begin
			reply_valid <= 1'b0;
			reply.baud <= link_baud;
			if (state == IRSL_CLOSING) begin
				reply_valid <= 1'b1;
				reply.kind <= `IRSL_KIND_CLOSE; // [RULE13]
			end else if (good_frame) begin
				unique case (state)
					IRSL_NDM: begin
						// Only slot 2 is answered, on every poll.
						if (rx_frame.kind == `IRSL_KIND_XID && rx_frame.slot == `IRSL_OWN_SLOT) begin
							reply_valid <= 1'b1; // [RULE3] [RULE4] [RULE6]
							reply.kind <= `IRSL_KIND_XID;
							reply.slot <= `IRSL_OWN_SLOT;
						end
					end
					IRSL_DISC_PARAMS: begin
						if (rx_frame.kind == `IRSL_KIND_PARAMS) begin
							reply_valid <= 1'b1; // [RULE7]
							reply.kind <= `IRSL_KIND_PARAMS;
							reply.baud <= `IRSL_MAX_BAUD; // [RULE8]
						end
					end
					IRSL_DISC_IAS: begin
						if (rx_frame.kind == `IRSL_KIND_QUERY) begin
							reply_valid <= 1'b1; // [RULE9]
							reply.kind <= `IRSL_KIND_QUERY;
						end
					end
					IRSL_NCM: begin
						// Every good frame except a close is answered here, empty or not, to keep the link alive.
						if (rx_frame.kind != `IRSL_KIND_CLOSE) begin
							reply_valid <= 1'b1; // [RULE12]
							reply.kind <= `IRSL_KIND_DATA;
						end
					end
					IRSL_CLOSING: begin
						reply_valid <= 1'b0;
					end
				endcase
			end
		end
	end

	// Link rate: default while disconnected, common rate after parameters.
	always_ff @(posedge clock) begin
		if (rst) begin
			link_baud <= `IRSL_DEFAULT_BAUD; // [RULE19]
		end else if (ce) begin
			if (next_state == IRSL_NDM) begin
				link_baud <= `IRSL_DEFAULT_BAUD; // [RULE1]
			end else if (state == IRSL_DISC_PARAMS && good_frame
				&& rx_frame.kind == `IRSL_KIND_PARAMS) begin
				link_baud <= (primary_baud < `IRSL_MAX_BAUD) ? primary_baud
					: `IRSL_MAX_BAUD; // [RULE7] [RULE8]
			end
		end
	end

	// Host flow control and carrier detect.
	always_ff @(posedge clock) begin
		if (rst) begin
			cts <= 1'b1; // [RULE19]
			carrier_detect <= 1'b0;
		end else if (ce) begin
			// High inhibits host; held outside connection and while receiving.
			cts <= (next_state != IRSL_NCM) || rx_active; // [RULE6] [RULE10] [RULE18] [RULE11]
			carrier_detect <= (next_state == IRSL_NCM); // [RULE17]
		end
	end

	// Payload reaches the host unchanged through the FIFO.
	irsl_fifo #(
		.WIDTH(`IRSL_FIFO_WIDTH),
		.DEPTH(`IRSL_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.in_valid(rx_byte_valid && state == IRSL_NCM), // [RULE15]
		.in_ready(fifo_in_ready),
		.in_data(rx_byte),
		.out_valid(host_valid),
		.out_ready(host_ready),
		.out_data(fifo_out_data)
	);
	assign host_data = fifo_out_data;
	assign rx_stall = !fifo_in_ready;
endmodule : irsl_link_fsm
`default_nettype wire

/* irsl_params.svh */
`ifndef IRSL_PARAMS_SVH
`define IRSL_PARAMS_SVH
// Link rates as baud figures.
`define IRSL_DEFAULT_BAUD 17'd9600
`define IRSL_MAX_BAUD 17'd115200
// The answered discovery slot.
`define IRSL_OWN_SLOT 8'h02
// Frame delimiters.
`define IRSL_FRAME_START 8'hC0
`define IRSL_FRAME_END 8'hC1
// Frame kinds reported by the frame decoder.
`define IRSL_KIND_XID 3'h0
`define IRSL_KIND_BCAST_ID 3'h1
`define IRSL_KIND_PARAMS 3'h2
`define IRSL_KIND_QUERY 3'h3
`define IRSL_KIND_DATA 3'h4
`define IRSL_KIND_CLOSE 3'h5
// Inactivity fallback time and clock rate.
`define IRSL_IDLE_TIMEOUT_S 10
`define IRSL_CLOCK_HZ 20000000
`define IRSL_IDLE_CYCLES (`IRSL_IDLE_TIMEOUT_S * `IRSL_CLOCK_HZ)
// Data FIFO shape.
`define IRSL_FIFO_WIDTH 8
`define IRSL_FIFO_DEPTH 4
`endif

/* irsl_pkg.sv */
`include "irsl_params.svh"
package irsl_pkg;
	// Link connection states.
	typedef enum logic [2:0] {
		IRSL_NDM,
		IRSL_DISC_PARAMS,
		IRSL_DISC_IAS,
		IRSL_NCM,
		IRSL_CLOSING
	} irsl_state_t;

	// A decoded received frame, checked for CRC by the decoder.
	typedef struct packed {
		logic [2:0] kind;
		logic [7:0] slot;
		logic crc_ok;
	} irsl_frame_t;

	// A response request to the frame encoder.
	typedef struct packed {
		logic [2:0] kind;
		logic [7:0] slot;
		logic [16:0] baud;
	} irsl_reply_t;
endpackage : irsl_pkg

/* irsl_link_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "irsl_params.svh"
// Watches the port behaviour of the link state machine.
module irsl_link_checker
	import irsl_pkg::*;
#(
	parameter int IDLE_CYCLES = 50
) (
	input wire logic clock, // Clock.
	input wire logic rst, // Reset.
	input wire logic ce, // Enable.
	input wire logic rx_frame_valid, // Frame strobe.
	input wire irsl_frame_t rx_frame, // Frame.
	input wire logic rx_active_pin, // Receive busy.
	input wire logic rx_stall, // Stall.
	input wire logic reply_valid, // Reply strobe.
	input wire irsl_reply_t reply, // Reply.
	input wire logic [16:0] link_baud, // Rate.
	input wire logic cts, // Host inhibit.
	input wire logic carrier_detect, // Linked.
	input wire logic [2:0] link_state // State.
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic take; // A good frame is taken.
	int idle; // Edges since the last frame while linked.
	assign take = ce && rx_frame_valid && rx_frame.crc_ok;
	// Counts silence on a live link; the limit below has one edge of slack.
	always_ff @(posedge clock) begin
		if (rst || link_state == 3'h0 || (ce && rx_frame_valid)) begin
			idle <= 0;
		end else if (ce) begin
			idle <= idle + 1;
		end
	end
	reset_state_a: assert property ($fell(rst) |-> cts && !carrier_detect
		&& link_baud == `IRSL_DEFAULT_BAUD && link_state == 3'h0) else $error("bad reset state");
	slot_answer_a: assert property (take && rx_frame.kind == `IRSL_KIND_XID
		&& link_state == 3'h0 |=> reply_valid == ($past(rx_frame.slot) == `IRSL_OWN_SLOT))
		else $error("slot answer wrong");
	slot_only_a: assert property (reply_valid && reply.kind == `IRSL_KIND_XID |->
		reply.slot == `IRSL_OWN_SLOT) else $error("answered foreign slot");
	rate_cap_a: assert property (link_baud <= `IRSL_MAX_BAUD && !(reply_valid
		&& reply.kind == `IRSL_KIND_PARAMS && reply.baud > `IRSL_MAX_BAUD)) else $error("rate high");
	default_rate_a: assert property (link_state == 3'h0 |->
		link_baud == `IRSL_DEFAULT_BAUD) else $error("poll rate wrong");
	setup_cts_a: assert property (link_state inside {3'h0, 3'h1, 3'h2} |-> cts)
		else $error("host not inhibited");
	setup_cd_a: assert property (link_state inside {3'h0, 3'h1, 3'h2} |->
		!carrier_detect) else $error("carrier without link");
	// The pin needs three sync stages, the filter and the output flop: six samples in all.
	rx_busy_a: assert property ((link_state == 3'h3 && rx_active_pin) [*6] |-> cts)
		else $error("host free during receive");
	close_seq_a: assert property (take && rx_frame.kind == `IRSL_KIND_CLOSE && link_state == 3'h3
		|=> link_state == 3'h4 ##1 (reply_valid && reply.kind == `IRSL_KIND_CLOSE
		&& link_state == 3'h0)) else $error("close sequence wrong");
	idle_limit_a: assert property (idle <= IDLE_CYCLES + 1)
		else $error("idle link kept");
	cover property (reply_valid && reply.kind == `IRSL_KIND_CLOSE);
	cover property (carrier_detect && link_state == 3'h3);
	cover property (rx_stall);
endmodule : irsl_link_checker
bind irsl_link_fsm irsl_link_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.clock(clock), .rst(rst),
	.ce(ce), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .rx_active_pin(rx_active_pin),
	.rx_stall(rx_stall), .reply_valid(reply_valid), .reply(reply), .link_baud(link_baud),
	.cts(cts), .carrier_detect(carrier_detect), .link_state(link_state));
`default_nettype wire

/* irsl_primary_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "irsl_params.svh"
// Remote primary station as seen after the frame decoder.
module irsl_primary_model
	import irsl_pkg::*;
(
	input wire logic clock, // System clock.
	input wire logic reply_valid, // Secondary answers.
	input wire irsl_reply_t reply, // Answer fields.
	output logic rx_frame_valid, // Frame strobe.
	output irsl_frame_t rx_frame, // Frame fields.
	output logic [16:0] primary_baud // Offered rate.
);
	initial begin
		rx_frame_valid = 1'b0;
		rx_frame = '0;
		primary_baud = 17'h00000;
	end
	// Sends one good frame after a gap, then scrambles the released lines.
	// A frame that follows another needs a gap of at least one edge.
	task automatic send(input logic [2:0] kind, input logic [7:0] slot, input int gap);
		repeat (gap) @(posedge clock);
		if (gap > 0) #1;
		rx_frame_valid = 1'b1;
		rx_frame = {kind, slot, 1'b1};
		@(posedge clock);
		#1;
		rx_frame_valid = 1'b0;
		rx_frame = ~rx_frame;
	endtask : send
	// Numbered discoveries from zero, then the identification; notes who answered.
	task automatic poll(input int n, output int hits, output logic [7:0] got);
		hits = 0;
		got = 8'hFF;
		for (int i = 0; i < n; i++) begin
			send(`IRSL_KIND_XID, i[7:0], 1);
			if (reply_valid === 1'b1) begin
				hits++;
				got = reply.slot;
			end
		end
		send(`IRSL_KIND_BCAST_ID, 8'h00, 1);
	endtask : poll
	// Offers the primary link parameters first.
	task automatic negotiate(input logic [16:0] rate);
		primary_baud = rate;
		send(`IRSL_KIND_PARAMS, 8'h00, 2);
		primary_baud = ~rate;
	endtask : negotiate
endmodule : irsl_primary_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "irsl_params.svh"
// Self-checking bench for the link state machine.
module tb;
	import irsl_pkg::*;
	localparam int IDLE = 50; // Short inactivity limit.
	logic clock, rst, ce, rx_active_pin, rx_byte_valid, host_ready, rx_frame_valid;
	logic reply_valid, host_valid, rx_stall, cts, carrier_detect;
	logic [7:0] rx_byte, host_data, got;
	logic [16:0] primary_baud, link_baud;
	logic [2:0] link_state;
	irsl_frame_t rx_frame;
	irsl_reply_t reply;
	int fail_count = 0;
	int tests_run = 0;
	int hits;
	irsl_link_fsm #(.IDLE_CYCLES(IDLE)) DUT (.clock(clock), .rst(rst), .ce(ce),
		.rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .rx_active_pin(rx_active_pin),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .primary_baud(primary_baud),
		.reply_valid(reply_valid), .reply(reply), .link_baud(link_baud), .host_valid(host_valid),
		.host_ready(host_ready), .host_data(host_data), .rx_stall(rx_stall), .cts(cts),
		.carrier_detect(carrier_detect), .link_state(link_state));
	irsl_primary_model PRIM (.clock(clock), .reply_valid(reply_valid), .reply(reply),
		.rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .primary_baud(primary_baud));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Waits n edges and lands just after the last one.
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict
	task automatic t_link();
		PRIM.send(`IRSL_KIND_XID, 8'h00, 0);
		check(reply_valid, 1'b0, "slot 0 answered");
		PRIM.send(`IRSL_KIND_BCAST_ID, 8'h00, 1);
		check(link_state, 3'h0, "early discovery");
		PRIM.poll(8, hits, got);
		check(hits, 1, "answer count");
		check(got, `IRSL_OWN_SLOT, "answer slot");
		check(link_state, 3'h1, "no discovery");
		PRIM.negotiate(17'd19200);
		check(reply_valid && reply.kind == `IRSL_KIND_PARAMS, 1'b1, "no params");
		check(reply.baud <= `IRSL_MAX_BAUD, 1'b1, "offer high");
		check(link_baud, 17'd19200, "rate not common");
		PRIM.send(`IRSL_KIND_QUERY, 8'h00, 1);
		check(reply_valid && reply.kind == `IRSL_KIND_QUERY, 1'b1, "no query answer");
		check(cts, 1'b1, "host free in setup");
		PRIM.send(`IRSL_KIND_DATA, 8'h00, 1);
		check(link_state, 3'h3, "not linked");
		check(carrier_detect, 1'b1, "no carrier");
		check(cts, 1'b0, "host held");
		$display("t_link done");
	endtask : t_link
	task automatic t_data();
		rx_byte_valid = 1'b1;
		for (int i = 0; i < 4; i++) begin
			rx_byte = 8'hA0 + i[7:0];
			tick(1);
		end
		rx_byte_valid = 1'b0;
		rx_byte = 8'h5C;
		check(rx_stall, 1'b1, "full not refused");
		host_ready = 1'b1;
		for (int i = 0; i < 4; i++) begin
			check({host_valid, host_data}, {1'b1, 8'hA0 + i[7:0]}, "byte order");
			tick(1);
		end
		host_ready = 1'b0;
		check(host_valid, 1'b0, "not drained");
		rx_active_pin = 1'b1;
		tick(6);
		check(cts, 1'b1, "host free in receive");
		rx_active_pin = 1'b0;
		tick(6);
		check(cts, 1'b0, "host kept held");
		// An empty frame on a live link must still be answered.
		PRIM.send(`IRSL_KIND_DATA, 8'h00, 1);
		check(reply_valid && reply.kind == `IRSL_KIND_DATA, 1'b1, "no keepalive");
		$display("t_data done");
	endtask : t_data
	task automatic t_close();
		PRIM.send(`IRSL_KIND_CLOSE, 8'h00, 1);
		check(link_state, 3'h4, "no closing");
		tick(1);
		check(reply_valid && reply.kind == `IRSL_KIND_CLOSE, 1'b1, "no confirm");
		check({link_state, carrier_detect, cts}, {3'h0, 1'b0, 1'b1}, "not dropped");
		check(link_baud, `IRSL_DEFAULT_BAUD, "rate kept");
		$display("t_close done");
	endtask : t_close
	task automatic t_idle();
		tick(IDLE - 5);
		check(link_state, 3'h3, "dropped early");
		tick(8);
		check(link_state, 3'h0, "not dropped");
		$display("t_idle done");
	endtask : t_idle
	initial begin
		tick(4000);
		fail_count++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		rx_active_pin = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		host_ready = 1'b0;
		tick(3);
		rst = 1'b0;
		check({cts, carrier_detect, host_valid, link_state}, 6'h20, "reset outputs");
		check(link_baud, `IRSL_DEFAULT_BAUD, "reset rate");
		t_link();
		t_data();
		t_close();
		t_link();
		t_idle();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
